// [alo_serial_out.sv]
// serial lane output stage: 16 lanes, bit clock, frame clock
`timescale 1ns/1ps
`include "alo_map.svh"
module alo_serial_out
   import alo_pkg::*;
(
   // core clock and reset
   input  wire logic                       mclk,
   input  wire logic                       rst_n,
   // link bit clock (serialiser clock)
   input  wire logic                       link_clk,
   // configuration pins
   input  wire logic                       double_rate_lane_sharing,
   input  wire logic                       high_rate_select,
   input  wire logic [`ALO_NUM_LANES-1:0]  lane_power_down_x,
   // clock input pins
   input  wire logic                       clock_input_positive,
   input  wire logic                       clock_input_negative,
   // converter samples, 16 channels x 14 bits, channel 1 in low bits
   input  wire logic [`ALO_NUM_CH*`ALO_RES_HI-1:0] sample_data,
   input  wire logic                       sample_valid,
   // serial outputs
   output logic                            serial_bit_clock,
   output logic                            frame_clock,
   output logic [`ALO_NUM_LANES-1:0]       serial_lane,
   output logic [`ALO_NUM_LANES-1:0]       lane_enable,
   // sampling clock status
   output logic                            sampling_clock,
   output logic                            clock_buffer_enable,
   output logic [`ALO_NUM_CH-1:0]          channel_sample_clock
);
   localparam int NW = `ALO_NUM_CH*`ALO_RES_HI;
   logic rst_sync1_reg, rst_sync2_reg, rst_core_n;
   logic lrst1_reg, lrst2_reg, lrst_n;

   // reset release through two flip-flops per domain
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync1_reg <= 1'b0;
         rst_sync2_reg <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_sync2_reg <= rst_sync1_reg;
      end
   end
   assign rst_core_n = rst_sync2_reg;
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         lrst1_reg <= 1'b0;
         lrst2_reg <= 1'b0;
      end else begin
         lrst1_reg <= 1'b1;
         lrst2_reg <= lrst1_reg;
      end
   end
   assign lrst_n = lrst2_reg;

   // negative clock input filtered in the core domain
   logic clock_input_negative_level;
   alo_sync3 u_clock_input_negative_sync (
      .clk   (mclk),
      .rst_n (rst_core_n),
      .d     (clock_input_negative),
      .q     (clock_input_negative_level)
   );

   // ground detect: a negative input stuck low for a full window is ground
   logic [`ALO_CNT_W-1:0] gnd_cnt_reg, gnd_cnt_next;
   alo_clk_mode_t clk_mode_reg, clk_mode_next;
   always_comb begin
      gnd_cnt_next  = gnd_cnt_reg;
      clk_mode_next = clk_mode_reg;
      if (clock_input_negative_level) begin
         gnd_cnt_next  = '0;
         clk_mode_next = ALO_CLK_DIFF;
      end else if (gnd_cnt_reg != '1) begin
         gnd_cnt_next = gnd_cnt_reg + 5'h01;
      end else begin
         clk_mode_next = ALO_CLK_SINGLE;
      end
   end
   always_ff @(posedge mclk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         gnd_cnt_reg  <= '0;
         clk_mode_reg <= ALO_CLK_DIFF;
      end else begin
         gnd_cnt_reg  <= gnd_cnt_next;
         clk_mode_reg <= clk_mode_next;
      end
   end
   assign clock_buffer_enable = (clk_mode_reg == ALO_CLK_DIFF);

   // one shared source fanned out equally; single-ended uses positive pin alone
   assign sampling_clock = clock_buffer_enable ?
                           (clock_input_positive & ~clock_input_negative) :
                           clock_input_positive;
   assign channel_sample_clock = {`ALO_NUM_CH{sampling_clock}};

   // sample handoff: core holds a word, link takes it by toggle handshake
   logic [NW-1:0] hold_reg, hold_next;
   logic          tog_reg, tog_next;
   logic          ack1_reg, ack2_reg, ack3_reg;
   logic          ltog1_reg, ltog2_reg, ltog3_reg;
   always_comb begin
      hold_next = hold_reg;
      tog_next  = tog_reg;
      // a new word is offered only once the link has taken the last one
      if (sample_valid && (ack2_reg == tog_reg)) begin
         hold_next = sample_data;
         tog_next  = ~tog_reg;
      end
   end
   always_ff @(posedge mclk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         hold_reg <= '0;
         tog_reg  <= 1'b0;
         ack1_reg <= 1'b0;
         ack2_reg <= 1'b0;
      end else begin
         hold_reg <= hold_next;
         tog_reg  <= tog_next;
         ack1_reg <= ltog3_reg;
         ack2_reg <= ack1_reg;
      end
   end

   // configuration pins into the link domain through filtered synchronisers;
   // applied only at a frame start, so one frame never mixes two settings
   logic [`ALO_NUM_LANES+1:0] cfg_pin, cfg_sync;
   assign cfg_pin = {double_rate_lane_sharing, high_rate_select, lane_power_down_x};
   for (genvar g = 0; g < `ALO_NUM_LANES+2; g++) begin : g_cfg_sync
      alo_sync3 u_alo_sync3 (
         .clk   (link_clk),
         .rst_n (lrst_n),
         .d     (cfg_pin[g]),
         .q     (cfg_sync[g])
      );
   end

   // offer toggle into the link domain
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         ltog1_reg <= 1'b0;
         ltog2_reg <= 1'b0;
      end else begin
         ltog1_reg <= tog_reg;
         ltog2_reg <= ltog1_reg;
      end
   end

   // link side: one output bit per link_clk cycle
   alo_rate_t             rate_reg, rate_next;
   logic                  hi_reg, hi_next;
   logic [`ALO_CNT_W-1:0] bit_reg, bit_next;
   logic [NW-1:0]         word_reg, word_next;
   logic [`ALO_NUM_LANES-1:0] lane_reg, lane_next, pd_reg, pd_next;
   logic                  frame_reg, frame_next, bclk_reg, bclk_next;

   function automatic logic [`ALO_CNT_W-1:0] res_bits(input logic hi);
      res_bits = hi ? 5'(`ALO_RES_LO) : 5'(`ALO_RES_HI);
   endfunction

   // sample bit of channel ch (0-based), msb first at bit index b
   function automatic logic ch_bit(input logic [NW-1:0] w, input int ch,
                                   input logic [`ALO_CNT_W-1:0] b,
                                   input logic [`ALO_CNT_W-1:0] res);
      logic [`ALO_CNT_W-1:0] pos;
      pos = 5'(res - 5'h01 - b) + 5'(`ALO_RES_HI - res);
      ch_bit = w[ch*`ALO_RES_HI + int'(pos)];
   endfunction

   // link-side acknowledge of the offered word
   logic ltog3_next;

   always_comb begin
      logic [`ALO_CNT_W-1:0] res, slots, half;
      res        = res_bits(hi_reg);
      // double rate takes twice the bit slots in the same frame
      slots      = (rate_reg == ALO_DOUBLE_RATE) ? 5'(2*res) : res;
      half       = '0;
      rate_next  = rate_reg;
      hi_next    = hi_reg;
      pd_next    = pd_reg;
      word_next  = word_reg;
      ltog3_next = ltog3_reg;
      bit_next   = bit_reg + 5'h01;
      // frame boundary: reload word and configuration
      if (bit_reg >= slots - 5'h01) begin
         bit_next = '0;
         if (ltog2_reg != ltog3_reg) begin
            word_next = hold_reg;
         end
         // acknowledge only at the boundary that took the word
         ltog3_next = ltog2_reg;
         rate_next  = cfg_sync[`ALO_NUM_LANES+1] ? ALO_DOUBLE_RATE : ALO_SINGLE_RATE;
         hi_next    = cfg_sync[`ALO_NUM_LANES];
         pd_next    = cfg_sync[`ALO_NUM_LANES-1:0];
      end
      // the frame being built uses the settings taken at its own start
      res        = res_bits(hi_next);
      half       = (rate_next == ALO_DOUBLE_RATE) ? res : 5'(res >> 1);
      frame_next = (bit_next < half);
      bclk_next  = ~bclk_reg;
      for (int l = 0; l < `ALO_NUM_LANES; l++) begin
         lane_next[l] = 1'b0;
         if (rate_next == ALO_SINGLE_RATE) begin
            lane_next[l] = ch_bit(word_next, l, bit_next, res);
         end else if ((l % 8) < 4) begin
            // frame high: odd channel, low: even channel of the pair
            // lanes 1-4 map channels 1-8, lanes 9-12 map 9-16
            // two channels share one active lane
            if (bit_next < res) begin
               lane_next[l] = ch_bit(word_next, (l/8)*8 + (l%8)*2, bit_next, res);
            end else begin
               lane_next[l] = ch_bit(word_next, (l/8)*8 + (l%8)*2 + 1,
                                     5'(bit_next - res), res);
            end
         end
      end
   end

   // link registers
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         rate_reg  <= ALO_SINGLE_RATE;
         hi_reg    <= 1'b0;
         pd_reg    <= '0;
         bit_reg   <= '0;
         word_reg  <= '0;
         lane_reg  <= '0;
         frame_reg <= 1'b0;
         bclk_reg  <= 1'b0;
         ltog3_reg <= 1'b0;
      end else begin
         rate_reg  <= rate_next;
         hi_reg    <= hi_next;
         pd_reg    <= pd_next;
         bit_reg   <= bit_next;
         word_reg  <= word_next;
         lane_reg  <= lane_next;
         frame_reg <= frame_next;
         bclk_reg  <= bclk_next;
         ltog3_reg <= ltog3_next;
      end
   end

   // bit clock toggles each link cycle, ddr style: one bit per half period
   assign serial_bit_clock = bclk_reg;
   assign frame_clock      = frame_reg;
   // lanes stay driven unless their own power-down bit is set
   assign serial_lane = lane_reg & ~pd_reg;
   assign lane_enable = ~pd_reg;
endmodule

// [alo_map.svh]
// constants for the serial lane output stage
`ifndef ALO_MAP_SVH
`define ALO_MAP_SVH
`define ALO_NUM_CH       16
`define ALO_NUM_LANES    16
`define ALO_RES_HI       14
`define ALO_RES_LO       12
`define ALO_RATE_HI_MSPS 65
`define ALO_RATE_LO_MSPS 80
`define ALO_CNT_W        5
`endif

// [alo_pkg.sv]
// types for the serial lane output stage
package alo_pkg;
   typedef enum logic {ALO_SINGLE_RATE, ALO_DOUBLE_RATE} alo_rate_t;
   typedef enum logic {ALO_CLK_DIFF, ALO_CLK_SINGLE} alo_clk_mode_t;
endpackage

// [alo_sync3.sv]
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module alo_sync3 (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // data
   input  wire logic d,
   output logic      q
);
   logic s1_reg, s2_reg, s3_reg, q_reg, q_next;

   // accept a change only when stages two and three agree
   always_comb begin
      q_next = q_reg;
      if (s2_reg == s3_reg) begin
         q_next = s2_reg;
      end
   end

   // register stages
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         q_reg  <= 1'b0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg  <= q_next;
      end
   end

   assign q = q_reg;
endmodule

// [alo_serial_out_chk.sv]
// checker for the serial lane output stage
`timescale 1ns/1ps
module alo_serial_out_chk (
   // clocks and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        link_clk,
   // configuration and clock pins
   input wire logic        double_rate_lane_sharing,
   input wire logic        high_rate_select,
   input wire logic [15:0] lane_power_down_x,
   input wire logic        clock_input_positive,
   input wire logic        clock_input_negative,
   // outputs watched
   input wire logic        serial_bit_clock,
   input wire logic        frame_clock,
   input wire logic [15:0] serial_lane,
   input wire logic [15:0] lane_enable,
   input wire logic        sampling_clock,
   input wire logic        clock_buffer_enable,
   input wire logic [15:0] channel_sample_clock
);
   logic [5:0]  cs, pc, nc;
   logic [4:0]  hi, per, eh;
   logic        fq, dq, hq, sr;
   logic [15:0] pq;
   assign eh = double_rate_lane_sharing ? (high_rate_select ? 5'h0c : 5'h0e)
                                        : (high_rate_select ? 5'h06 : 5'h07);
   // run lengths; config must settle a few frames before it is judged
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         {cs, hi, per, fq, dq, hq, sr} <= '0;
      end else begin
         fq <= frame_clock;
         {dq, hq} <= {double_rate_lane_sharing, high_rate_select};
         cs <= ({dq, hq} != {double_rate_lane_sharing, high_rate_select}) ? 6'h00
               : (cs == 6'h3f ? cs : cs + 6'h01);
         hi <= frame_clock ? hi + 5'h01 : 5'h00;
         per <= (frame_clock && !fq) ? 5'h01 : per + 5'h01;
         sr <= sr | (frame_clock && !fq);
      end
   end
   // stable-input counters in the core domain
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         {pc, nc, pq} <= '0;
      end else begin
         pq <= lane_power_down_x;
         pc <= (pq != lane_power_down_x) ? 6'h00 : (pc == 6'h3f ? pc : pc + 6'h01);
         nc <= clock_input_negative ? 6'h00 : (nc == 6'h3f ? nc : nc + 6'h01);
      end
   end
   property p_frhigh;
      @(posedge link_clk) disable iff (!rst_n) fq && !frame_clock && cs == 6'h3f |-> hi == eh;
   endproperty
   a_frhigh: assert property (p_frhigh) else $error("frame high length wrong");
   property p_frper;
      @(posedge link_clk) disable iff (!rst_n) sr && frame_clock && !fq && cs == 6'h3f
         |-> per == {eh[3:0], 1'b0};
   endproperty
   a_frper: assert property (p_frper) else $error("frame period wrong");
   property p_bitclk;
      @(posedge link_clk) disable iff (!rst_n) $rose(frame_clock)
         |-> serial_bit_clock != $past(serial_bit_clock);
   endproperty
   a_bitclk: assert property (p_bitclk) else $error("bit clock not toggling");
   property p_lanedn;
      @(posedge link_clk) disable iff (!rst_n) (serial_lane & ~lane_enable) == 16'h0000;
   endproperty
   a_lanedn: assert property (p_lanedn) else $error("disabled lane active");
   property p_laneen;
      @(posedge mclk) disable iff (!rst_n) pc == 6'h3f |-> lane_enable == ~lane_power_down_x;
   endproperty
   a_laneen: assert property (p_laneen) else $error("lane enable wrong");
   property p_bufoff;
      @(posedge mclk) disable iff (!rst_n) nc == 6'h3f |-> !clock_buffer_enable;
   endproperty
   a_bufoff: assert property (p_bufoff) else $error("clock buffer still on");
   property p_tree;
      @(posedge mclk) disable iff (!rst_n) channel_sample_clock == {16{sampling_clock}};
   endproperty
   a_tree: assert property (p_tree) else $error("channel clocks differ");
   property p_smp;
      @(posedge mclk) disable iff (!rst_n) sampling_clock == clock_input_positive;
   endproperty
   a_smp: assert property (p_smp) else $error("sampling clock wrong");
   property p_idle;
      @(posedge link_clk) disable iff (!rst_n) dq && cs == 6'h3f
         |-> (serial_lane & 16'hf0f0) == 16'h0000;
   endproperty
   a_idle: assert property (p_idle) else $error("idle lane carries data");
endmodule
bind alo_serial_out alo_serial_out_chk u_alo_serial_out_chk (.*);

// [alo_rx_model.sv]
// receiver model: deserialises every lane once per frame
`timescale 1ns/1ps
module alo_rx_model (
   input wire logic        link_clk,
   input wire logic        frame_clock,
   input wire logic [15:0] serial_lane,
   output logic [27:0]     word [16],
   output int              n_frames
);
   logic [27:0] acc [16];
   logic        fq = 1'b0;
   initial n_frames = 0;
   // frame rise opens
   // high half holds the odd channel, so the split is by position
   always @(posedge link_clk) begin
      fq <= frame_clock;
      for (int l = 0; l < 16; l++) begin
         if (frame_clock && !fq) begin
            word[l] <= acc[l];
            acc[l] <= {27'h0, serial_lane[l]};
         end else begin
            acc[l] <= {acc[l][26:0], serial_lane[l]};
         end
      end
      if (frame_clock && !fq)
         n_frames <= n_frames + 1;
   end
endmodule

// [tb_alo_serial_out.sv]
// testbench for the serial lane output stage
`timescale 1ns/1ps
module tb_alo_serial_out;
   logic mclk = 0, link_clk = 0, rst_n = 0, dbl = 0, hrs = 0, sv = 0, cp = 0, cn = 1, se = 0;
   logic ph = 0;
   logic [15:0]  pd = '0, sl, le;
   logic [223:0] sd = '0, sdv;
   logic         fc, cbe;
   logic [27:0]  word [16];
   int           n_frames, failures = 0, n_tests = 0;
   always #25 mclk = ~mclk;
   initial begin
      #1.3;
      forever #3 link_clk = ~link_clk;
   end
   // clock pins at a quarter of mclk so the pin filter sees two equal samples;
   // differential pair, or negative pin grounded
   always @(posedge mclk) begin
      ph <= ~ph;
      cp <= ph ? ~cp : cp;
      cn <= se ? 1'b0 : (ph ? cp : ~cp);
   end
   alo_serial_out u_alo_serial_out (.mclk(mclk), .rst_n(rst_n), .link_clk(link_clk),
      .double_rate_lane_sharing(dbl), .high_rate_select(hrs), .lane_power_down_x(pd),
      .clock_input_positive(cp), .clock_input_negative(cn), .sample_data(sd),
      .sample_valid(sv), .serial_bit_clock(), .frame_clock(fc), .serial_lane(sl),
      .lane_enable(le), .sampling_clock(), .clock_buffer_enable(cbe),
      .channel_sample_clock());
   alo_rx_model u_alo_rx_model (.link_clk(link_clk), .frame_clock(fc), .serial_lane(sl),
      .word(word), .n_frames(n_frames));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk_w(input logic [27:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t word %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_f(input logic [15:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t flags %h exp %h", $time, got, exp);
      end
   endtask
   // bounded wait for whole frames seen by the receiver
   task automatic frames(input int n);
      int s;
      s = n_frames;
      for (int i = 0; i < 4000 && n_frames < s + n; i++) @(posedge mclk);
      if (n_frames < s + n) begin
         failures++;
         wrap_up();
      end
   endtask
   task automatic t_stream(input logic d, h);
      int r, j;
      logic [27:0] c0, c1, m;
      @(posedge mclk);
      dbl <= d;
      hrs <= h;
      frames(5);
      r = h ? 12 : 14;
      m = (28'h1 << (d ? 2 * r : r)) - 28'h1;
      for (int l = 0; l < 16; l++) begin
         j = l < 8 ? l : l - 4;
         c0 = 28'(d ? sdv[28*j +: 14] : sdv[14*l +: 14]) >> (14 - r);
         c1 = 28'(sdv[28*j+14 +: 14]) >> (14 - r);
         if (!d) chk_w(word[l] & m, c0);
         else if (l % 8 < 4) chk_w(word[l] & m, (c0 << r) | c1);
         else chk_w(word[l] & m, 28'h0000000);
      end
      $display("stream test rate %0d res %0d done", d, r);
   endtask
   task automatic t_pdown;
      chk_f(le, 16'hffff);
      @(posedge mclk);
      pd <= 16'hf0f0;
      frames(5);
      chk_f(le, 16'h0f0f);
      @(posedge mclk);
      pd <= 16'h0000;
      $display("power down test done");
   endtask
   task automatic t_clk;
      chk_f(16'(cbe), 16'h0001);
      @(posedge mclk);
      se <= 1'b1;
      repeat (70) @(posedge mclk);
      chk_f(16'(cbe), 16'h0000);
      $display("clock mode test done");
   endtask
   initial begin
      for (int c = 0; c < 16; c++) sdv[14*c +: 14] = 14'h1a5b ^ 14'(c * 337);
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      sd <= sdv;
      sv <= 1'b1;
      t_stream(1'b0, 1'b0);
      t_stream(1'b0, 1'b1);
      t_stream(1'b1, 1'b0);
      t_stream(1'b1, 1'b1);
      t_pdown();
      t_clk();
      wrap_up();
   end
endmodule
